// ===== src/drc_pkg.sv
package drc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, chosen)
    // ------------------------------------------------------------
    localparam logic [11:0] RST0_OFS     = 12'h000;
    localparam logic [11:0] RST1_OFS     = 12'h004;
    localparam logic [11:0] PWRCTL_OFS   = 12'h008;
    localparam logic [11:0] STATUS_OFS   = 12'h00c;
    localparam logic [11:0] RETCTL_OFS   = 12'h010;

    // ------------------------------------------------------------
    // reset_control_reg_zero fields
    // ------------------------------------------------------------
    localparam int PERIPH_RST_BIT = 29;
    localparam int SOFT_RST_BIT   = 30;
    localparam int SYS_RST_BIT    = 31;
    localparam int PER_BITS       = 29;

    // power control fields
    localparam int MODE_LSB       = 0;
    localparam int HFIO_AUTO_BIT  = 4;
    localparam int AOD_AUTO_BIT   = 5;

    // reset values
    localparam logic [31:0] RST_RESET    = 32'h0000_0000;
    localparam logic [31:0] PWRCTL_RESET = 32'h0000_0000;
    localparam logic [31:0] RETCTL_RESET = 32'h0000_0000;

    // timing: reset pulse length in cycles
    localparam int RST_HOLD_NS   = 160;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DRC_ACTIVE = 2'b00,
        DRC_SLEEP  = 2'b01,
        DRC_DEEP   = 2'b11,
        DRC_BACKUP = 2'b10
    } drc_mode_t;

    typedef enum logic [1:0]
    {
        DRC_IDLE  = 2'b00,
        DRC_HOLD  = 2'b01,
        DRC_DONE  = 2'b11
    } drc_state_t;

    typedef enum logic [1:0]
    {
        DRC_LVL_PERIPH = 2'b00,
        DRC_LVL_SOFT   = 2'b01,
        DRC_LVL_SYS    = 2'b10,
        DRC_LVL_POR    = 2'b11
    } drc_level_t;

endpackage

// ===== src/drc_sync.sv
module drc_sync
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin side
    input  wire logic din,
    // clean level
    output logic      dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // change counts once second and third stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout <= s3_q;
        end
    end
endmodule

// ===== src/drc_top.sv
// Local design decisions: the APB interface to the registers and the register offsets.
module drc_top
#(
    parameter int NUM_PER = 29,
    parameter int HOLD_CYC = drc_pkg::RST_HOLD_CYC
)
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // event inputs
    input  wire logic        wdt_rst_pin,
    input  wire logic        sleep_req,
    input  wire logic        sleepdeep,
    // reset outputs, active low except gpio_alt_tristate and cpu_reset_vector_fetch
    output logic [NUM_PER-1:0] periph_rst_n,
    output logic             dma_rst_n,
    output logic             flash_rst_n,
    output logic             cache_rst_n,
    output logic             gpio_rst_n,
    output logic             gpio_alt_tristate,
    output logic             gcr_rst_n,
    output logic             clkcfg_rst_n,
    output logic             cpu_rst_n,
    output logic             wdt_rst_n,
    output logic             aod_rst_n,
    output logic             ramret_rst_n,
    output logic             cpu_reset_vector_fetch,
    // power and clock enables
    output logic             osc8k_en,
    output logic             hfio_en,
    output logic             hclk_en,
    output logic             pclk_en,
    output logic             cpu_clk_en,
    output logic             core_supply_en,
    output logic             dma_en,
    output logic             wdt_en,
    output logic             flash_en,
    output logic             cache_en,
    output logic             aod_en,
    output logic             sram_ret_en,
    output logic             cache_ret_en,
    output logic             fifo_ret_en,
    output logic             active_mode
);
    import drc_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [31:0]        rst0_q;
    logic [31:0]        rst1_q;
    logic [31:0]        pwrctl_q;
    logic [31:0]        retctl_q;
    logic [NUM_PER-1:0] per_rst0_q;
    logic [31:0]        per_rst1_q;
    drc_state_t         st_q;
    drc_state_t         st_d;
    drc_level_t         lvl_q;
    logic [7:0]         cnt_q;
    logic               gcr_hit_q;
    logic               sys_busy_q;
    logic               wdt_lvl;
    logic               wdt_prev_q;
    logic               por_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_en   = psel & penable & pwrite;
    wire rd_en   = psel & ~pwrite;
    wire hit_r0  = paddr == RST0_OFS;
    wire hit_r1  = paddr == RST1_OFS;
    wire hit_pc  = paddr == PWRCTL_OFS;
    wire hit_st  = paddr == STATUS_OFS;
    wire hit_rc  = paddr == RETCTL_OFS;
    wire mapped  = hit_r0 | hit_r1 | hit_pc | hit_st | hit_rc;
    wire wr_r0   = wr_en & hit_r0;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // watchdog event
    // ------------------------------------------------------------
    drc_sync u_wdt_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (wdt_rst_pin),
        .dout    (wdt_lvl)
    );

    wire wdt_evt = wdt_lvl & ~wdt_prev_q;

    // ------------------------------------------------------------
    // reset requests and level choice
    // ------------------------------------------------------------
    wire req_sys  = (wr_r0 & pwdata[SYS_RST_BIT]) | wdt_evt;
    wire req_soft = wr_r0 & pwdata[SOFT_RST_BIT];
    wire req_per  = wr_r0 & pwdata[PERIPH_RST_BIT];
    wire req_any  = req_sys | req_soft | req_per;

    wire drc_level_t new_lvl = req_sys  ? DRC_LVL_SYS  :
                               req_soft ? DRC_LVL_SOFT : DRC_LVL_PERIPH;

    wire holding = (st_q == DRC_HOLD);
    wire hold_end = holding && (cnt_q == 8'(HOLD_CYC - 1));

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            DRC_IDLE: if (req_any) st_d = DRC_HOLD;
            DRC_HOLD: if (hold_end) st_d = DRC_DONE;
            DRC_DONE: st_d = DRC_IDLE;
            default:  st_d = DRC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q  <= DRC_IDLE;
            lvl_q <= DRC_LVL_POR;
            cnt_q <= 8'h00;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= holding ? cnt_q + 8'h01 : 8'h00;
            if (st_q == DRC_IDLE && req_any)
                lvl_q <= new_lvl;
            else if (holding && req_any && new_lvl > lvl_q)
                lvl_q <= new_lvl;
        end
    end

    // por marker: set in reset, cleared at the first clock after power-on release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            por_q <= 1'b1;
        else
            por_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // nested reset domains
    // ------------------------------------------------------------
    wire lvl_ge_soft = holding & (lvl_q != DRC_LVL_PERIPH);
    wire lvl_sys     = holding & (lvl_q == DRC_LVL_SYS);
    wire any_rst     = holding;

    // peripherals reset on every level, or singly
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PER; gi++)
        begin : g_per
            assign periph_rst_n[gi] = ~(por_q | any_rst | per_rst0_q[gi]);
        end
    endgenerate

    assign dma_rst_n     = ~(por_q | any_rst | per_rst1_q[0]);
    assign flash_rst_n   = ~(por_q | any_rst | per_rst1_q[1]);
    assign cache_rst_n   = ~(por_q | any_rst | per_rst1_q[2]);
    assign gpio_rst_n    = ~(por_q | lvl_ge_soft);
    assign gpio_alt_tristate = ~gpio_rst_n;
    assign gcr_rst_n     = ~(por_q | lvl_sys);
    assign clkcfg_rst_n  = ~(por_q | lvl_sys);
    assign cpu_rst_n     = ~(por_q | lvl_sys);
    assign wdt_rst_n     = ~(por_q | lvl_sys);
    assign aod_rst_n     = ~por_q;
    assign ramret_rst_n  = ~por_q;
    assign cpu_reset_vector_fetch = (st_q == DRC_DONE) & (lvl_q == DRC_LVL_SYS);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst0_q     <= RST_RESET;
            rst1_q     <= RST_RESET;
            per_rst0_q <= '0;
            per_rst1_q <= 32'h0000_0000;
            wdt_prev_q <= 1'b0;
            sys_busy_q <= 1'b0;
        end
        else
        begin
            wdt_prev_q <= wdt_lvl;
            sys_busy_q <= holding;
            // per-peripheral bits act one cycle, then clear
            per_rst0_q <= (wr_r0) ? pwdata[NUM_PER-1:0] : '0;
            per_rst1_q <= (wr_en & hit_r1) ? pwdata : 32'h0000_0000;
            if (wr_en & hit_r1)
                rst1_q <= pwdata;
            else
                rst1_q <= 32'h0000_0000;
            // request bits: set wins, clear on completion
            if (req_any)
            begin
                rst0_q[SYS_RST_BIT]    <= rst0_q[SYS_RST_BIT] | req_sys;
                rst0_q[SOFT_RST_BIT]   <= rst0_q[SOFT_RST_BIT] | req_soft;
                rst0_q[PERIPH_RST_BIT] <= rst0_q[PERIPH_RST_BIT] | req_per;
            end
            else if (st_q == DRC_DONE)
                rst0_q <= RST_RESET;
            if (lvl_sys)
                rst0_q[PER_BITS-1:0] <= '0;
        end
    end

    // power control, global side reset by system reset; retention control is not
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwrctl_q <= PWRCTL_RESET;
        else if (lvl_sys)
            pwrctl_q <= PWRCTL_RESET;
        else if (wr_en & hit_pc)
            pwrctl_q <= pwdata;
    end

    // retention scope lives in always-on domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            retctl_q <= RETCTL_RESET;
        else if (wr_en & hit_rc)
            retctl_q <= pwdata;
    end

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    wire drc_mode_t mode = !sleep_req ? DRC_ACTIVE :
                           pwrctl_q[MODE_LSB+2] ? DRC_BACKUP :
                           sleepdeep ? DRC_DEEP : DRC_SLEEP;
    wire low_off  = (mode == DRC_DEEP) | (mode == DRC_BACKUP);
    wire hfio_auto = pwrctl_q[HFIO_AUTO_BIT];
    wire aod_auto  = pwrctl_q[AOD_AUTO_BIT];

    assign osc8k_en       = 1'b1;
    assign hfio_en        = holding | ~((mode == DRC_BACKUP) |
                            ((mode == DRC_DEEP) & hfio_auto));
    assign hclk_en        = holding | ~low_off;
    assign pclk_en        = holding | ~low_off;
    assign cpu_clk_en     = holding | (mode == DRC_ACTIVE);
    assign core_supply_en = holding | ~low_off;
    assign dma_en         = ~low_off;
    assign wdt_en         = ~low_off;
    assign flash_en       = ~low_off;
    assign cache_en       = ~low_off;
    assign active_mode    = holding | (mode == DRC_ACTIVE);
    assign aod_en         = ~((mode == DRC_BACKUP) & aod_auto);

    // single scope for all retained memories
    wire ret_on = retctl_q[0] & ~((mode == DRC_BACKUP) & aod_auto);
    assign sram_ret_en  = ret_on;
    assign cache_ret_en = ret_on;
    assign fifo_ret_en  = ret_on;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [31:0] status_w = {26'h0, sys_busy_q, holding, mode, lvl_q};
    wire [31:0] rd_mux = hit_r0 ? rst0_q   :
                         hit_r1 ? rst1_q   :
                         hit_pc ? pwrctl_q :
                         hit_st ? status_w :
                         hit_rc ? {31'h0, retctl_q[0]} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en & ~penable)
            prdata <= rd_mux;
    end
endmodule

// ===== bench/drc_top_asserts.sv
module drc_top_chk
#(
    parameter int NUM_PER  = 29,
    parameter int HOLD_CYC = 4
)
(
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // events
    input wire logic               wdt_rst_pin,
    input wire logic               sleep_req,
    input wire logic               sleepdeep,
    // resets
    input wire logic [NUM_PER-1:0] periph_rst_n,
    input wire logic               gpio_rst_n,
    input wire logic               gpio_alt_tristate,
    input wire logic               gcr_rst_n,
    input wire logic               clkcfg_rst_n,
    input wire logic               cpu_rst_n,
    input wire logic               wdt_rst_n,
    input wire logic               aod_rst_n,
    input wire logic               ramret_rst_n,
    input wire logic               cpu_reset_vector_fetch,
    // enables
    input wire logic               osc8k_en,
    input wire logic               hclk_en,
    input wire logic               pclk_en,
    input wire logic               cpu_clk_en,
    input wire logic               core_supply_en,
    input wire logic               dma_en,
    input wire logic               wdt_en,
    input wire logic               flash_en,
    input wire logic               cache_en,
    input wire logic               aod_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    osc_always_on_a : assert property (osc8k_en) else $error("8k osc off");
    aod_kept_a :
        assert property (aod_rst_n |=> aod_rst_n && ramret_rst_n) else $error("aod reset");
    sys_nest_a :
        assert property (!cpu_rst_n |-> !gcr_rst_n && !wdt_rst_n && !clkcfg_rst_n && !gpio_rst_n)
        else $error("system reset incomplete");
    soft_nest_a :
        assert property (!gpio_rst_n |-> gpio_alt_tristate && periph_rst_n == '0)
        else $error("soft reset incomplete");
    sys_keeps_aod_a :
        assert property ($fell(gcr_rst_n) |-> aod_rst_n && ramret_rst_n) else $error("aod hit");
    sys_hold_len_a :
        assert property ($fell(cpu_rst_n) |-> !cpu_rst_n [*4] ##1 cpu_rst_n)
        else $error("hold length");
    wdt_to_sys_a :
        assert property ($rose(wdt_rst_pin) |-> ##[2:10] !cpu_rst_n) else $error("wdt lost");
    vector_pulse_a :
        assert property (cpu_reset_vector_fetch |=> !cpu_reset_vector_fetch)
        else $error("vector pulse long");
    sleep_gate_a :
        assert property ((sleep_req && !sleepdeep) [*3] |->
            !cpu_clk_en && hclk_en && pclk_en && core_supply_en && aod_en)
        else $error("sleep gating");
    deep_gate_a :
        assert property ((sleep_req && sleepdeep) [*3] |-> aod_en && !(hclk_en || pclk_en
            || cpu_clk_en || core_supply_en || dma_en || wdt_en || flash_en || cache_en))
        else $error("deep gating");

    cover property ($fell(cpu_rst_n));
    cover property ($fell(gpio_rst_n) && cpu_rst_n);
    cover property (sleep_req && sleepdeep && !hclk_en);
endmodule

bind drc_top drc_top_chk #(.NUM_PER(NUM_PER), .HOLD_CYC(HOLD_CYC)) u_chk (.*);

// ===== bench/drc_wdt_model.sv
module drc_wdt_model
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // bench command
    input  wire logic bite,
    // event toward the block
    output logic      wdt_rst_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q;

    // held long enough to cross the 3-stage synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 3'h0;
        else if (bite)
            cnt_q <= 3'h6;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    assign wdt_rst_pin = (cnt_q != 3'h0);
endmodule

// ===== bench/drc_top_tb.sv
module drc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import drc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        wdt_rst_pin, sleep_req, sleepdeep, bite;
    logic [28:0] periph_rst_n;
    logic        dma_rst_n, flash_rst_n, cache_rst_n, gpio_rst_n, gpio_alt_tristate;
    logic        gcr_rst_n, clkcfg_rst_n, cpu_rst_n, wdt_rst_n, aod_rst_n, ramret_rst_n;
    logic        cpu_reset_vector_fetch, osc8k_en, hfio_en, hclk_en, pclk_en, cpu_clk_en;
    logic        core_supply_en, dma_en, wdt_en, flash_en, cache_en, aod_en;
    logic        sram_ret_en, cache_ret_en, fifo_ret_en, active_mode;
    int          err_count, total_checks;
    wire logic [4:0] mon = {dma_rst_n, cpu_reset_vector_fetch, cpu_rst_n, gpio_rst_n,
                            periph_rst_n[0]};

    drc_top #(.NUM_PER(29), .HOLD_CYC(4)) uut (.*);
    drc_wdt_model wdt (.*);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, 32'(pready));
        if (n >= 50)
            report_and_stop();
    endtask

    task automatic wait_mon(input int i, input logic v);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (mon[i] !== v && n < 30);
        chk("level", 32'(v), 32'(mon[i]));
        if (n >= 30)
            report_and_stop();
    endtask

    task automatic t_por();
        @(negedge pclk);
        chk("released", 32'hff, 32'({&periph_rst_n, dma_rst_n, gpio_rst_n, cpu_rst_n,
            aod_rst_n, ramret_rst_n, gcr_rst_n, wdt_rst_n}));
        chk("clocks", 32'h7f, 32'({osc8k_en, hfio_en, hclk_en, pclk_en, cpu_clk_en,
            core_supply_en, active_mode}));
        apb(1'b0, RST0_OFS, 32'h0);
        chk("rst0", RST_RESET, rd);
        apb(1'b0, RETCTL_OFS, 32'h0);
        chk("retctl", RETCTL_RESET, rd);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h3, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", 32'h1, 32'(serr));
    endtask

    task automatic t_single();
        apb(1'b1, RETCTL_OFS, 32'h1);
        apb(1'b1, RST0_OFS, 32'h1);
        wait_mon(0, 1'b0);
        chk("single", 32'h7, 32'({periph_rst_n[1], gpio_rst_n, dma_rst_n}));
        apb(1'b1, RST1_OFS, 32'h1);
        wait_mon(4, 1'b0);
        chk("dma only", 32'h7, 32'({periph_rst_n[0], flash_rst_n, cache_rst_n}));
    endtask

    task automatic t_lvl(input int b, input logic [9:0] e, input logic vec);
        if (b < 0)
        begin
            @(posedge pclk);
            bite <= 1'b1;
            @(posedge pclk);
            bite <= 1'b0;
        end
        else
            apb(1'b1, RST0_OFS, 32'h1 << b);
        wait_mon(0, 1'b0);
        chk("levels", 32'(e), 32'({|periph_rst_n, dma_rst_n, gpio_rst_n, gpio_alt_tristate,
            cpu_rst_n, gcr_rst_n, wdt_rst_n, clkcfg_rst_n, aod_rst_n, ramret_rst_n}));
        if (vec)
            wait_mon(3, 1'b1);
        repeat (8) @(negedge pclk);
        chk("after", 32'h1, 32'(&periph_rst_n & cpu_rst_n & gpio_rst_n));
        apb(1'b0, RST0_OFS, 32'h0);
        chk("rst0 clear", 32'h0, rd);
        apb(1'b0, RETCTL_OFS, 32'h0);
        chk("retention", 32'h1, rd);
    endtask

    task automatic t_power();
        @(negedge pclk);
        chk("ret", 32'h7, 32'({sram_ret_en, cache_ret_en, fifo_ret_en}));
        apb(1'b1, PWRCTL_OFS, 32'h1 << HFIO_AUTO_BIT);
        sleep_req <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("sleep", 32'hf, 32'({cpu_clk_en, hclk_en, pclk_en, core_supply_en, aod_en}));
        @(posedge pclk);
        sleepdeep <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("deep", 32'h3, 32'({hclk_en, pclk_en, cpu_clk_en, core_supply_en, dma_en, wdt_en,
            flash_en, cache_en, hfio_en, aod_en, osc8k_en}));
        @(posedge pclk);
        sleep_req <= 1'b0;
        sleepdeep <= 1'b0;
        repeat (4) @(negedge pclk);
        chk("wake", 32'hf, 32'({cpu_clk_en, hclk_en, hfio_en, active_mode}));
        // backup mode select, always-on kept
        apb(1'b1, PWRCTL_OFS, 32'h4);
        sleep_req <= 1'b1;
        sleepdeep <= 1'b1;
        repeat (4) @(negedge pclk);
        chk("backup", 32'h6, 32'({hfio_en, aod_en, sram_ret_en, hclk_en}));
        @(posedge pclk);
        sleep_req <= 1'b0;
        sleepdeep <= 1'b0;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleep_req = 1'b0;
        sleepdeep = 1'b0;
        bite = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_por();
        t_single();
        t_lvl(PERIPH_RST_BIT, 10'h0bf, 1'b0);
        t_lvl(SOFT_RST_BIT, 10'h07f, 1'b0);
        t_lvl(SYS_RST_BIT, 10'h043, 1'b1);
        t_lvl(-1, 10'h043, 1'b1);
        t_power();
        report_and_stop();
    end
endmodule
